// *** design/abd_pkg.sv ***
package abd_pkg;

    // Register offsets on the plain register port.
    localparam logic [2:0] ABD_OFF_CTRL     = 3'h0;
    localparam logic [2:0] ABD_OFF_DIV_LO   = 3'h1;
    localparam logic [2:0] ABD_OFF_DIV_HI   = 3'h2;
    localparam logic [2:0] ABD_OFF_RXBUF    = 3'h3;
    localparam logic [2:0] ABD_OFF_STATUS   = 3'h4;
    localparam logic [2:0] ABD_OFF_INT_STAT = 3'h5;
    localparam logic [2:0] ABD_OFF_INT_CLR  = 3'h6;
    localparam logic [2:0] ABD_OFF_INT_EN   = 3'h7;

    // Field positions in the baud control register.
    localparam int ABD_CTRL_EN_BIT   = 0;
    localparam int ABD_CTRL_OVF_BIT  = 1;
    localparam int ABD_CTRL_WIDE_BIT = 3;
    localparam int ABD_CTRL_HS_BIT   = 4;

    // Field positions in the status register.
    localparam int ABD_STAT_RXIF_BIT = 0;
    localparam int ABD_STAT_BUSY_BIT = 1;

    // Interrupt event bits: calibration done, counter overflow.
    localparam int ABD_EV_DONE_BIT = 0;
    localparam int ABD_EV_OVF_BIT  = 1;

    // Values after reset.
    localparam logic [15:0] ABD_DIV_RST      = 16'h0000;
    localparam logic [7:0]  ABD_BYTE_RST     = 8'h00;
    localparam logic [1:0]  ABD_EV_RST       = 2'h0;
    localparam logic [8:0]  ABD_PRESC_RST    = 9'h000;
    localparam logic [2:0]  ABD_EDGES_RST    = 3'h0;

    // Counter start value, the rising-edge count after which the next rise ends a
    // measurement, and the largest value of the 16-bit counter.
    localparam logic [15:0] ABD_COUNT_START  = 16'h0001;
    localparam logic [2:0]  ABD_LAST_EDGE    = 3'h4;
    localparam logic [15:0] ABD_COUNT_MAX    = 16'hFFFF;

    // Auto-baud clock terminal counts: system clock divided by 32, 128, 512.
    localparam logic [8:0]  ABD_DIV32_TC     = 9'h01F;
    localparam logic [8:0]  ABD_DIV128_TC    = 9'h07F;
    localparam logic [8:0]  ABD_DIV512_TC    = 9'h1FF;

    // Measurement sequence states, one-hot.
    typedef enum logic [3:0] {
        ABD_IDLE      = 4'h1,
        ABD_WAIT_FALL = 4'h2,
        ABD_WAIT_RISE = 4'h4,
        ABD_COUNT     = 4'h8
    } abd_state_t;

    // Receive line as seen after synchronisation.
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } abd_edge_t;

    // State of the synchroniser.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } abd_sync_t;

    // State of the calibration core.
    typedef struct packed {
        abd_state_t  st;
        logic [2:0]  edges;
        logic [8:0]  presc;
        logic [15:0] div;
        logic        en;
        logic        ovf;
        logic        wide;
        logic        hs;
        logic        rxif;
        logic [1:0]  int_stat;
        logic [1:0]  int_en;
        logic [7:0]  rdata;
        logic        irq;
        logic        hold;
    } abd_core_t;

endpackage

// *** design/abd_rx_sync.sv ***
`timescale 1ns/1ps
module abd_rx_sync
    import abd_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      rx_in,
    output abd_edge_t      edges
);

    abd_sync_t q_r;
    abd_sync_t q_nxt;

    // Two flops take the pin into the clock domain; the third only
    // remembers the previous clean level, so the first flop feeds nothing else.
    always_comb begin
        q_nxt    = q_r;
        q_nxt.s1 = rx_in;
        q_nxt.s2 = q_r.s1;
        q_nxt.s3 = q_r.s2;
    end

    // The idle serial line is high, so the chain resets high.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
        end else begin
            q_r <= q_nxt;
        end
    end

    // Single-cycle edge pulses from the clean level.
    assign edges.level = q_r.s2;
    assign edges.rise  = q_r.s2 & ~q_r.s3;
    assign edges.fall  = ~q_r.s2 & q_r.s3;

endmodule // abd_rx_sync

// *** design/abd_autobaud.sv ***
//
// Contract
// - Setting enable starts calibration on receive line.
// - Receiver held idle during calibration.
// - Count starts at first rise after start.
// - Fifth rising edge ends the measurement.
// - Keep count, clear enable, set receive flag.
// - Reading receive buffer clears the flag.
// - Divisor pair counts as one 16-bit counter.
// - Counter advances at one eighth base clock.
// - Counter clock chosen by wide and speed bits.
// - Dividers 32, 128, 128, 512 of system clock.
// - Overflow sets flag, counting continues to end.
// - Overflow clear refused while enable still set.
// - Counter starts at one; software subtracts one.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module abd_autobaud
    import abd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        RX_LINE,
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output      logic [7:0]  RDATA,
    output      logic        IRQ,
    output      logic        RX_HOLD_IDLE,
    output      logic        RX_FLAG,
    output      logic [15:0] BAUD_DIVISOR,
    output      logic        WIDE_DIVISOR_SELECT,
    output      logic        HIGH_SPEED_SELECT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Terminal count of the auto-baud prescaler for the selected mode.
    // The base clock is divided by eight more, so the count is the bit time.
    function automatic logic [8:0] abd_presc_tc(input logic wide, input logic hs);
        logic [8:0] tc;
        tc = ABD_DIV128_TC;
        if (wide && hs) begin
            tc = ABD_DIV32_TC;
        end else if (!wide && !hs) begin
            tc = ABD_DIV512_TC;
        end
        return tc;
    endfunction

    // Packs the baud control register.
    function automatic logic [7:0] abd_ctrl_byte(input abd_core_t s);
        logic [7:0] b;
        b                    = ABD_BYTE_RST;
        b[ABD_CTRL_EN_BIT]   = s.en;
        b[ABD_CTRL_OVF_BIT]  = s.ovf;
        b[ABD_CTRL_WIDE_BIT] = s.wide;
        b[ABD_CTRL_HS_BIT]   = s.hs;
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Receive line conditioning.

    abd_edge_t rx_e;

    abd_rx_sync u_sync (
        .clk   (CLK),
        .rst   (RST),
        .rx_in (RX_LINE),
        .edges (rx_e)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Core state.

    abd_core_t s_r;
    abd_core_t s_nxt;

    logic       wr_ctrl;
    logic       wr_lo;
    logic       wr_hi;
    logic       wr_iclr;
    logic       wr_ien;
    logic       rd_buf;
    logic       tick;
    logic       done;
    logic       ovf_set;
    logic       ovf_clr;
    logic [1:0] ev_set;
    logic [7:0] rd_val;

    // Address decode of the register port.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_lo   = 1'b0;
        wr_hi   = 1'b0;
        wr_iclr = 1'b0;
        wr_ien  = 1'b0;
        rd_buf  = 1'b0;
        if (WR && ADDR == ABD_OFF_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (WR && ADDR == ABD_OFF_DIV_LO) begin
            wr_lo = 1'b1;
        end else if (WR && ADDR == ABD_OFF_DIV_HI) begin
            wr_hi = 1'b1;
        end else if (WR && ADDR == ABD_OFF_INT_CLR) begin
            wr_iclr = 1'b1;
        end else if (WR && ADDR == ABD_OFF_INT_EN) begin
            wr_ien = 1'b1;
        end else if (RD && ADDR == ABD_OFF_RXBUF) begin
            rd_buf = 1'b1;
        end
    end

    // Read mux; unmapped and write-only offsets read as zero. The receive
    // buffer has no data path here and answers zero, which software discards.
    always_comb begin
        rd_val = ABD_BYTE_RST;
        if (ADDR == ABD_OFF_CTRL) begin
            rd_val = abd_ctrl_byte(s_r);
        end else if (ADDR == ABD_OFF_DIV_LO) begin
            rd_val = s_r.div[7:0];
        end else if (ADDR == ABD_OFF_DIV_HI) begin
            rd_val = s_r.div[15:8];
        end else if (ADDR == ABD_OFF_STATUS) begin
            rd_val[ABD_STAT_RXIF_BIT] = s_r.rxif;
            rd_val[ABD_STAT_BUSY_BIT] = s_r.st != ABD_IDLE;
        end else if (ADDR == ABD_OFF_INT_STAT) begin
            rd_val[1:0] = s_r.int_stat;
        end else if (ADDR == ABD_OFF_INT_EN) begin
            rd_val[1:0] = s_r.int_en;
        end
    end

    // Measurement events of this cycle.
    always_comb begin
        tick    = (s_r.st == ABD_COUNT) && (s_r.presc == abd_presc_tc(s_r.wide, s_r.hs));
        done    = (s_r.st == ABD_COUNT) && rx_e.rise && (s_r.edges == ABD_LAST_EDGE);
        ovf_set = tick && (s_r.div == ABD_COUNT_MAX);
        // An overflow clear only counts once enable is already low.
        ovf_clr = wr_ctrl && !WDATA[ABD_CTRL_OVF_BIT] && !s_r.en;
        ev_set  = ABD_EV_RST;
        ev_set[ABD_EV_DONE_BIT] = done;
        ev_set[ABD_EV_OVF_BIT]  = ovf_set;
    end

    // Next state: measurement first, then software, with hardware sets
    // winning over any clear that lands in the same cycle.
    always_comb begin
        s_nxt = s_r;

        // Measurement sequence.
        case (s_r.st)
            ABD_IDLE: begin
                s_nxt.presc = ABD_PRESC_RST;
                s_nxt.edges = ABD_EDGES_RST;
            end
            ABD_WAIT_FALL: begin
                if (rx_e.fall) begin
                    s_nxt.st = ABD_WAIT_RISE;
                end
            end
            ABD_WAIT_RISE: begin
                // The end of the start bit opens the count at one.
                if (rx_e.rise) begin
                    s_nxt.st    = ABD_COUNT;
                    s_nxt.div   = ABD_COUNT_START;
                    s_nxt.presc = ABD_PRESC_RST;
                    s_nxt.edges = 3'(s_r.edges + 3'h1);
                end
            end
            ABD_COUNT: begin
                // Prescaler gives the 1/8 base-clock enable for the counter.
                if (tick) begin
                    s_nxt.presc = ABD_PRESC_RST;
                    s_nxt.div   = 16'(s_r.div + 16'h0001);
                end else begin
                    s_nxt.presc = 9'(s_r.presc + 9'h001);
                end
                if (rx_e.rise) begin
                    s_nxt.edges = 3'(s_r.edges + 3'h1);
                end
                // Fifth rising edge: leave the count, drop enable, flag it.
                if (done) begin
                    s_nxt.st = ABD_IDLE;
                    s_nxt.en = 1'b0;
                end
            end
            default: begin
                s_nxt.st = ABD_IDLE;
            end
        endcase

        // Baud control writes. Clearing enable aborts a running measurement.
        if (wr_ctrl) begin
            s_nxt.wide = WDATA[ABD_CTRL_WIDE_BIT];
            s_nxt.hs   = WDATA[ABD_CTRL_HS_BIT];
            if (WDATA[ABD_CTRL_EN_BIT] && !s_r.en) begin
                s_nxt.en    = 1'b1;
                s_nxt.st    = ABD_WAIT_FALL;
                s_nxt.edges = ABD_EDGES_RST;
            end else if (!WDATA[ABD_CTRL_EN_BIT]) begin
                s_nxt.en = 1'b0;
                s_nxt.st = ABD_IDLE;
            end
        end

        // Divisor writes only land while the sequence is idle, since
        // the measurement owns the pair from enable until completion or abort.
        if (wr_lo && s_r.st == ABD_IDLE) begin
            s_nxt.div[7:0] = WDATA;
        end
        if (wr_hi && s_r.st == ABD_IDLE) begin
            s_nxt.div[15:8] = WDATA;
        end

        // Overflow flag: set wins over a permitted clear.
        s_nxt.ovf = (s_r.ovf && !ovf_clr) || ovf_set;

        // Receive flag: cleared by a buffer read, but a completion wins.
        s_nxt.rxif = (s_r.rxif && !rd_buf) || done;

        // Sticky interrupt status, write-one-to-clear, set wins.
        if (wr_iclr) begin
            s_nxt.int_stat = s_r.int_stat & ~WDATA[1:0];
        end
        s_nxt.int_stat = s_nxt.int_stat | ev_set;
        if (wr_ien) begin
            s_nxt.int_en = WDATA[1:0];
        end

        // Registered outputs.
        s_nxt.irq   = |(s_nxt.int_stat & s_nxt.int_en);
        s_nxt.hold  = s_nxt.en;
        s_nxt.rdata = RD ? rd_val : ABD_BYTE_RST;
    end

    // Single state register.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '{st:       ABD_IDLE,
                     edges:    ABD_EDGES_RST,
                     presc:    ABD_PRESC_RST,
                     div:      ABD_DIV_RST,
                     int_stat: ABD_EV_RST,
                     int_en:   ABD_EV_RST,
                     rdata:    ABD_BYTE_RST,
                     default:  1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.

    assign RDATA               = s_r.rdata;
    assign IRQ                 = s_r.irq;
    assign RX_HOLD_IDLE        = s_r.hold;
    assign RX_FLAG             = s_r.rxif;
    assign BAUD_DIVISOR        = s_r.div;
    assign WIDE_DIVISOR_SELECT = s_r.wide;
    assign HIGH_SPEED_SELECT   = s_r.hs;

endmodule // abd_autobaud

// *** tb/abd_autobaud_assertions.sv ***
`timescale 1ns/1ps
module abd_autobaud_assertions
    import abd_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [2:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        IRQ,
    input wire logic        RX_HOLD_IDLE,
    input wire logic        RX_FLAG,
    input wire logic [15:0] BAUD_DIVISOR,
    input wire logic        WIDE_DIVISOR_SELECT,
    input wire logic        HIGH_SPEED_SELECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic [15:0] prev_r;
    logic [9:0]  gap_r;
    logic [1:0]  sel_r;
    logic [9:0]  per;
    // Tick period from the selects; a select change mid-count would confuse it.
    assign per = (WIDE_DIVISOR_SELECT && HIGH_SPEED_SELECT) ? 10'h020 :
                 (WIDE_DIVISOR_SELECT ^ HIGH_SPEED_SELECT) ? 10'h080 : 10'h200;
    // Cycles since the divisor last moved, and the select bits of the previous cycle's write data.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prev_r <= 16'h0000;
            gap_r  <= 10'h000;
            sel_r  <= 2'h0;
        end else begin
            prev_r <= BAUD_DIVISOR;
            gap_r  <= (BAUD_DIVISOR != prev_r) ? 10'h000 : gap_r + 10'h001;
            sel_r  <= WDATA[ABD_CTRL_HS_BIT:ABD_CTRL_WIDE_BIT];
        end
    end
    sequence s_start;
        WR && ADDR == ABD_OFF_CTRL && WDATA[ABD_CTRL_EN_BIT] && !RX_HOLD_IDLE;
    endsequence
    sequence s_int_off;
        WR && ADDR == ABD_OFF_INT_EN && WDATA[1:0] == 2'h0 ##1 !(WR && ADDR == ABD_OFF_INT_EN);
    endsequence
    chk_enable_starts: assert property (s_start |=> RX_HOLD_IDLE)
        else $error("calibration did not start");
    chk_done_sets_flag: assert property ($fell(RX_HOLD_IDLE) && !$past(WR) |-> RX_FLAG)
        else $error("completion without receive flag");
    chk_flag_only_done: assert property ($rose(RX_FLAG) |-> $fell(RX_HOLD_IDLE))
        else $error("receive flag set outside completion");
    chk_div_frozen: assert property (!RX_HOLD_IDLE && !$past(RX_HOLD_IDLE) && !$past(WR)
        |-> $stable(BAUD_DIVISOR))
        else $error("divisor moved while idle");
    chk_count_step: assert property (RX_HOLD_IDLE && $changed(BAUD_DIVISOR)
        |-> BAUD_DIVISOR == $past(BAUD_DIVISOR) + 16'h0001
            || BAUD_DIVISOR == ABD_COUNT_START)
        else $error("counter step wrong");
    chk_tick_spacing: assert property (RX_HOLD_IDLE && BAUD_DIVISOR != prev_r
        && BAUD_DIVISOR != ABD_COUNT_START |-> gap_r == per - 10'h001)
        else $error("counter tick period wrong");
    chk_select_bits: assert property (WR && ADDR == ABD_OFF_CTRL
        |=> {HIGH_SPEED_SELECT, WIDE_DIVISOR_SELECT} == sel_r)
        else $error("select bits not taken");
    // A completion in the same cycle as the buffer read keeps the flag set.
    chk_rxbuf_clear: assert property (RD && ADDR == ABD_OFF_RXBUF
        |=> RDATA == 8'h00 && (!RX_FLAG || $fell(RX_HOLD_IDLE)))
        else $error("buffer read did not clear flag");
    chk_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data outside read cycle");
    chk_irq_masked: assert property (s_int_off |=> !IRQ)
        else $error("interrupt high while masked");
endmodule // abd_autobaud_assertions

bind abd_autobaud abd_autobaud_assertions u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .RX_HOLD_IDLE(RX_HOLD_IDLE), .RX_FLAG(RX_FLAG), .BAUD_DIVISOR(BAUD_DIVISOR),
    .WIDE_DIVISOR_SELECT(WIDE_DIVISOR_SELECT), .HIGH_SPEED_SELECT(HIGH_SPEED_SELECT));

// *** tb/abd_sync_tx.sv ***
`timescale 1ns/1ps
module abd_sync_tx (
    input  wire logic clk,
    output      logic line
);
    // The line idles high between frames, as a released serial line does.
    initial line = 1'b1;
    // Start, data LSB first, stop; a short count cuts the frame for aborts.
    task automatic send(input logic [7:0] b, input int t, input int nbits);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < nbits; i++) begin
            @(posedge clk);
            line <= fr[i];
            repeat (t - 1) @(posedge clk);
        end
        @(posedge clk);
        line <= 1'b1;
    endtask
endmodule // abd_sync_tx

// *** tb/abd_autobaud_test.sv ***
`timescale 1ns/1ps
module abd_autobaud_test;
    import abd_pkg::*;
    logic        CLK, RST, WR, RD, rx, IRQ, hold, flag, wide, hs;
    logic [2:0]  ADDR;
    logic [7:0]  WDATA, RDATA;
    logic [15:0] div;
    int          error_cnt, tests_run, cyc;
    logic [7:0]  mode [4] = '{8'h18, 8'h08, 8'h10, 8'h00};
    logic [7:0]  exp_lo [4] = '{8'h53, 8'h15, 8'h15, 8'h06};

    abd_autobaud u_abd_autobaud (.CLK(CLK), .RST(RST), .RX_LINE(rx), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .RX_HOLD_IDLE(hold), .RX_FLAG(flag), .BAUD_DIVISOR(div),
        .WIDE_DIVISOR_SELECT(wide), .HIGH_SPEED_SELECT(hs));
    abd_sync_tx u_abd_sync_tx (.clk(CLK), .line(rx));

    // 200 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 chk(16'(RDATA), 16'(exp));
    endtask

    // A hang ends the run; the ceiling is well above the expected 14.6k cycles.
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end

    //////////////////////////////////////////////////
    initial begin
        RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 3'h0; WDATA = 8'h00;
        error_cnt = 0; tests_run = 0; cyc = 0;
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        rd(ABD_OFF_CTRL, 8'h00);
        rd(ABD_OFF_DIV_LO, 8'h00);
        rd(ABD_OFF_DIV_HI, 8'h00);
        rd(ABD_OFF_INT_EN, 8'h00);
        // Read-only places ignore writes.
        wr(ABD_OFF_STATUS, 8'hFF);
        rd(ABD_OFF_STATUS, 8'h00);
        wr(ABD_OFF_INT_STAT, 8'hFF);
        rd(ABD_OFF_INT_STAT, 8'h00);
        // Abort mid-character: the count stops and no flag is raised.
        wr(ABD_OFF_CTRL, 8'h19);
        u_abd_sync_tx.send(8'h55, 330, 4);
        chk(16'(hold), 16'h0001);
        wr(ABD_OFF_CTRL, 8'h18);
        // The abort lands at the edge the task returns on, so look just after it.
        #1 chk(16'(hold), 16'h0000);
        chk(16'(flag), 16'h0000);
        // One full sync character in every divider mode; interrupt masked first.
        for (int i = 0; i < 4; i++) begin
            wr(ABD_OFF_INT_EN, (i == 0) ? 8'h00 : 8'h01);
            wr(ABD_OFF_CTRL, mode[i] | 8'h01);
            rd(ABD_OFF_STATUS, 8'h02);
            fork
                u_abd_sync_tx.send(8'h55, 330, 10);
                begin
                    repeat (1000) @(posedge CLK);
                    chk(16'(hold), 16'h0001);
                    wr(ABD_OFF_DIV_LO, 8'hAA);
                end
            join
            chk(16'(hold), 16'h0000);
            chk(16'(flag), 16'h0001);
            chk(16'(IRQ), 16'(i != 0));
            rd(ABD_OFF_DIV_LO, exp_lo[i]);
            rd(ABD_OFF_DIV_HI, 8'h00);
            rd(ABD_OFF_CTRL, mode[i]);
            chk(div, {8'h00, exp_lo[i]});
            chk(16'({hs, wide}), 16'(mode[i][4:3]));
            rd(ABD_OFF_INT_STAT, 8'h01);
            rd(ABD_OFF_RXBUF, 8'h00);
            chk(16'(flag), 16'h0000);
            wr(ABD_OFF_INT_CLR, 8'h03);
            rd(ABD_OFF_INT_STAT, 8'h00);
            chk(16'(IRQ), 16'h0000);
        end
        results();
    end
endmodule // abd_autobaud_test
